/* File: rtl/bt_wdt_pkg.sv */
// Package with register map, field layout and constants of the basic timer and watchdog.
package bt_wdt_pkg;

	localparam logic [3:0]  ADDR_TIMER_CONTROL  = 4'h0;
	localparam logic [3:0]  ADDR_TIMER_COUNT    = 4'h4;
	localparam logic [3:0]  ADDR_WATCHDOG_COUNT = 4'h8;
	localparam int          ADDR_LSB            = 0;
	localparam int          ADDR_MSB            = 3;
	localparam int          WDOG_CLR_BIT        = 0;
	localparam int          TIMER_CLR_BIT       = 1;
	localparam int          SEL_LSB             = 2;
	localparam int          SEL_MSB             = 4;
	localparam int          WEN_LSB             = 5;
	localparam int          WEN_MSB             = 7;
	localparam int          IRQ_EN_BIT          = 8;
	localparam int          STAB_BIT            = 5;
	localparam logic [2:0]  WDOG_OFF_SIG        = 3'h5;
	localparam logic [2:0]  WDOG_ON_RESET       = 3'h0;
	localparam logic [7:0]  COUNT_MAX           = 8'hFF;
	localparam logic [10:0] DIV_ONE             = 11'h001;

	typedef struct packed {
		logic [7:0] count;
		logic       pulse;
	} count_state_t;

	// Divide ratio minus one for each clock select code.
	function automatic logic [10:0] div_limit(input logic [2:0] sel);
		logic [10:0] r;
		r = 11'h001;
		unique case (sel)
			3'h0: r = 11'h001;
			3'h1: r = 11'h003;
			3'h2: r = 11'h00F;
			3'h3: r = 11'h01F;
			3'h4: r = 11'h07F;
			3'h5: r = 11'h0FF;
			3'h6: r = 11'h3FF;
			3'h7: r = 11'h7FF;
		endcase
		return r;
	endfunction : div_limit

endpackage : bt_wdt_pkg

/* File: rtl/count_if.sv */
// Interface carrying a counter's step, clear and result signals.
`timescale 1ns/100ps
interface count_if;
	logic       step;
	logic       clear;
	logic [7:0] count;
	logic       wrap;
	modport ctr (input step, input clear, output count, output wrap);
	modport user (output step, output clear, input count, input wrap);
endinterface : count_if

/* File: rtl/wrap_counter.sv */
// Eight-bit counter with clear and a one-cycle wrap pulse.
`timescale 1ns/100ps
module wrap_counter (
	input  wire logic clock,
	input  wire logic rst_n,
	count_if.ctr      cif
);
	import bt_wdt_pkg::*;

	count_state_t state_reg;
	count_state_t state_next;

	always_comb begin
		state_next       = state_reg;
		state_next.pulse = 1'b0;
		if (cif.clear) begin
			state_next.count = '0;
		end else if (cif.step) begin
			state_next.count = state_reg.count + 8'h01;
			state_next.pulse = (state_reg.count == COUNT_MAX);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign cif.count = state_reg.count;
	assign cif.wrap  = state_reg.pulse;

endmodule : wrap_counter

/* File: rtl/bt_wdt.sv */
// Basic timer with watchdog counter, stabilisation gate and APB register slave.
//
// Overview of operation
// R1: Only signature 101 in enable field disables watchdog.
// R2: Reset clears control register; watchdog enabled.
// R3: Option bit picks enable field reset value.
// R4: Watchdog counter overflow while enabled forces reset.
// R5: Watchdog counter steps on timer overflow pulse.
// R6: Writing one to bit 0 clears watchdog.
// R7: Writing one to bit 1 clears timer.
// R8: Select codes divide main clock 2 to 2048.
// R9: Clock select reset value comes from option.
// R10: Software changes select only after stabilisation; the code accepts select writes at any time, also while the CPU clock is held.
// R11: CPU clock held until timer bit 5 overflows.
// R12: Power-on uses option rate; wake keeps programmed rate.
// R13: Bit 8 enables timer interrupt, resets zero.
// R14: Software clears watchdog before it overflows.
// R15: Timer count reads in low byte only.
// R16: Watchdog count reads in low byte only.
// R17: Timer steps per tick, pulses and interrupts on wrap.
// R18: Reserved control bits read zero, ignore writes.
`timescale 1ns/100ps
module bt_wdt (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        opt_wdog_enable,
	input  wire logic [2:0]  opt_prescale_select,
	input  wire logic        stop_wake,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             watchdog_reset,
	output logic             cpu_clock_hold,
	output logic             timer_irq,
	output logic             timer_overflow_pulse
);
	import bt_wdt_pkg::*;

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        init_done;
		logic [2:0]  watchdog_enable_field;
		logic [2:0]  prescale_select;
		logic        timer_irq_enable;
		logic [10:0] div;
		logic        hold;
		logic        wake_s1;
		logic        wake_s2;
		logic        wdog_rst;
		logic        irq;
		logic [31:0] rdata;
	} top_state_t;

	top_state_t state_reg;
	top_state_t state_next;

	count_if timer_cif ();
	count_if wdog_cif ();

	wrap_counter timer_ctr (
		.clock (clock),
		.rst_n (rst_n),
		.cif   (timer_cif.ctr)
	);

	wrap_counter wdog_ctr (
		.clock (clock),
		.rst_n (rst_n),
		.cif   (wdog_cif.ctr)
	);

	logic        wr_ctl;
	logic        access;
	logic        tick;
	logic        wdog_on;
	logic        stab_done;
	logic        addr_ok;
	logic [3:0]  addr;

	// ----------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------
	assign addr    = paddr[ADDR_MSB:ADDR_LSB];
	assign addr_ok = (paddr[31:ADDR_MSB+1] == '0) && ((addr == ADDR_TIMER_CONTROL) ||
		(addr == ADDR_TIMER_COUNT) || (addr == ADDR_WATCHDOG_COUNT));
	assign access  = psel && penable;
	assign wr_ctl  = access && pwrite && (addr == ADDR_TIMER_CONTROL) && addr_ok;
	assign pready  = 1'b1;
	assign pslverr = access && !addr_ok;

	// ----------------------------------------------------------------
	// Prescaler, counters and stabilisation.
	// ----------------------------------------------------------------
	assign tick      = (state_reg.div >= div_limit(state_reg.prescale_select)); // [R8]
	assign wdog_on   = (state_reg.watchdog_enable_field != WDOG_OFF_SIG); // [R1]
	assign stab_done = state_reg.hold && tick && (timer_cif.count[STAB_BIT:0] == COUNT_MAX[STAB_BIT:0]); // [R11]

	assign timer_cif.step  = tick; // [R17]
	assign timer_cif.clear = wr_ctl && pwdata[TIMER_CLR_BIT]; // [R7]
	assign wdog_cif.step   = timer_cif.wrap; // [R5]
	assign wdog_cif.clear  = wr_ctl && pwdata[WDOG_CLR_BIT]; // [R6]

	always_comb begin
		state_next           = state_reg;
		state_next.init_done = 1'b1;
		state_next.wake_s1   = stop_wake;
		state_next.wake_s2   = state_reg.wake_s1;
		state_next.div       = tick ? '0 : state_reg.div + DIV_ONE;
		if (!state_reg.init_done) begin
			state_next.watchdog_enable_field = opt_wdog_enable ? WDOG_ON_RESET : WDOG_OFF_SIG; // [R3]
			state_next.prescale_select       = opt_prescale_select; // [R9] [R12]
			state_next.hold                  = 1'b1; // [R11]
		end else if (wr_ctl) begin
			state_next.timer_irq_enable      = pwdata[IRQ_EN_BIT]; // [R13] [R18]
			state_next.watchdog_enable_field = pwdata[WEN_MSB:WEN_LSB];
			state_next.prescale_select       = pwdata[SEL_MSB:SEL_LSB];
		end
		if (state_reg.wake_s2) begin
			state_next.hold = 1'b1; // [R12]
		end else if (stab_done) begin
			state_next.hold = 1'b0; // [R11]
		end
		state_next.wdog_rst = wdog_on && wdog_cif.wrap; // [R4]
		state_next.irq      = state_reg.timer_irq_enable && timer_cif.wrap; // [R17]
		state_next.rdata    = '0;
		if (psel && !penable && !pwrite) begin
			unique case (addr)
				ADDR_TIMER_CONTROL: begin
					state_next.rdata[IRQ_EN_BIT]      = state_reg.timer_irq_enable; // [R18]
					state_next.rdata[WEN_MSB:WEN_LSB] = state_reg.watchdog_enable_field;
					state_next.rdata[SEL_MSB:SEL_LSB] = state_reg.prescale_select;
				end
				ADDR_TIMER_COUNT: begin
					state_next.rdata[7:0] = timer_cif.count; // [R15]
				end
				ADDR_WATCHDOG_COUNT: begin
					state_next.rdata[7:0] = wdog_cif.count; // [R16]
				end
				default: begin
					state_next.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= '0; // [R2]
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata               = state_reg.rdata;
	assign watchdog_reset       = state_reg.wdog_rst;
	assign cpu_clock_hold       = state_reg.hold || !state_reg.init_done;
	assign timer_irq            = state_reg.irq;
	assign timer_overflow_pulse = timer_cif.wrap;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	signature_off_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
		(state_reg.init_done && state_reg.watchdog_enable_field == WDOG_OFF_SIG) |=> !watchdog_reset)
		else $error("Watchdog reset while disabled by signature.");

	wdog_reset_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
		(wdog_cif.wrap && wdog_on) |=> watchdog_reset)
		else $error("Watchdog overflow did not reset.");

	wdog_step_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
		(!timer_cif.wrap && !wdog_cif.clear) |=> $stable(wdog_cif.count))
		else $error("Watchdog counter moved without timer overflow.");

	wdog_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
		wdog_cif.clear |=> (wdog_cif.count == 8'h00))
		else $error("Watchdog counter not cleared.");

	timer_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
		timer_cif.clear |=> (timer_cif.count == 8'h00))
		else $error("Timer counter not cleared.");

	opt_load_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
		!state_reg.init_done |=> (state_reg.watchdog_enable_field == (opt_wdog_enable ? 3'h0 : 3'h5)))
		else $error("Enable field not loaded from option.");

	hold_release_a: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
		(stab_done && !state_reg.wake_s2) |=> !cpu_clock_hold)
		else $error("CPU clock not released after stabilisation.");

	timer_irq_a: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
		timer_cif.wrap |=> (timer_irq == state_reg.timer_irq_enable || $past(wr_ctl)))
		else $error("Timer interrupt does not follow overflow.");

	irq_masked_a: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
		!state_reg.timer_irq_enable |=> !timer_irq)
		else $error("Timer interrupt raised while disabled.");

	upper_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
		prdata[31:IRQ_EN_BIT+1] == '0)
		else $error("Reserved read data bits not zero.");

	wake_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
		state_reg.wake_s2 |=> cpu_clock_hold)
		else $error("Wake did not hold the CPU clock.");

	ovf_single_a: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
		timer_overflow_pulse |=> !timer_overflow_pulse)
		else $error("Timer overflow pulse longer than one cycle.");

endmodule : bt_wdt

/* File: tb/tb.sv */
// Self-checking testbench for the basic timer and watchdog block.
`timescale 1ns/100ps
module tb;
	import bt_wdt_pkg::*;
	logic        clock, rst_n, opt_wdog_enable, stop_wake, psel, penable, pwrite;
	logic [2:0]  opt_prescale_select;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        pready, pslverr, watchdog_reset, cpu_clock_hold, timer_irq, timer_overflow_pulse, er;
	int          num_errors, samples_checked, n, c, irqs, resets;
	int          dv[3] = '{2, 4, 16};

	bt_wdt i_dut (.clock, .rst_n, .opt_wdog_enable, .opt_prescale_select, .stop_wake, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .watchdog_reset, .cpu_clock_hold,
		.timer_irq, .timer_overflow_pulse);

	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end

	always @(posedge clock) begin
		if (timer_irq === 1'b1) irqs++;
		if (watchdog_reset === 1'b1) resets++;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1;
		n = 0;
		do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
		@(posedge clock);
	endtask : apb

	task wait_ovf;
		c = 0;
		do begin @(posedge clock); c++; end while (timer_overflow_pulse !== 1'b1 && c < 9000);
	endtask : wait_ovf

	task wait_hold;
		n = 0;
		while (cpu_clock_hold !== 1'b0 && n < 400) begin @(posedge clock); n++; end
	endtask : wait_hold

	task do_reset(input logic oe, input logic [2:0] os);
		rst_n <= 0; opt_wdog_enable <= oe; opt_prescale_select <= os;
		repeat (5) @(posedge clock);
		rst_n <= 1;
		check(cpu_clock_hold, 1);
		@(posedge clock);
	endtask : do_reset

	task print_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_n = 0; opt_wdog_enable = 0; opt_prescale_select = 3'h0; stop_wake = 0;
		psel = 0; penable = 0; pwrite = 0; paddr = 32'h0; pwdata = 32'h0;
		do_reset(1'b0, 3'h0);
		apb(0, 32'h0, 32'h0); check(rd, 32'h000000A0);
		wait_hold; check(32'(n > 100 && n < 200), 1);
		do_reset(1'b1, 3'h1);
		apb(0, 32'h0, 32'h0); check(rd, 32'h00000004);
		wait_hold; check(32'(n > 220 && n < 320), 1);
		$display("test reset done");
		apb(1, 32'h0, 32'hFFFFFFFF);
		apb(0, 32'h0, 32'h0); check(rd, 32'h000001FC);
		apb(0, 32'hC, 32'h0); check(er, 1); check(rd, 32'h0);
		$display("test registers done");
		for (int s = 0; s < 3; s++) begin
			apb(1, 32'h0, 32'hA2 | (s << 2));
			wait_ovf;
			wait_ovf; check(c, 256 * dv[s]);
		end
		$display("test prescale done");
		apb(1, 32'h0, 32'hA1);
		apb(0, 32'h8, 32'h0); check(rd, 32'h0);
		wait_ovf; repeat (3) @(posedge clock);
		apb(0, 32'h8, 32'h0); check(rd, 32'h1);
		apb(1, 32'h0, 32'hA0);
		apb(0, 32'h8, 32'h0); check(rd, 32'h1);
		apb(1, 32'h0, 32'hA2);
		apb(0, 32'h4, 32'h0); check(32'(rd < 8), 1);
		$display("test clear done");
		irqs = 0;
		wait_ovf; wait_ovf; repeat (3) @(posedge clock); check(irqs, 0);
		apb(1, 32'h0, 32'h1A0);
		wait_ovf; repeat (3) @(posedge clock); check(irqs, 1);
		$display("test interrupt done");
		apb(1, 32'h0, 32'h1A2);
		stop_wake <= 1;
		@(posedge clock);
		stop_wake <= 0;
		repeat (4) @(posedge clock);
		check(cpu_clock_hold, 1);
		wait_hold; check(32'(n > 100 && n < 200), 1);
		check(resets, 0);
		$display("test wake done");
		print_verdict;
	end

	initial begin
		#300us;
		num_errors++;
		print_verdict;
	end
endmodule : tb
